// ==== rtl/ssb_sequencer.sv ====
// standstill window monitor and holding brake sequencer
// Notes on behaviour
// - after move end, motion-end rises once deviation stayed in window for dwell time
// - window size 16 bit, 0..32767, default 10; standstill only inside it
// - dwell zero disables window monitoring; otherwise dwell in ms up to 32767
// - timeout zero disables timeout monitor; otherwise timeout in ms up to 16000
// - error raised when window not reached before timeout elapsed
// - timeout count starts at target reached or profile generator finished
// - brake-release goes high once stage enabled and motor holds torque
// - brake-release high means released or releasing, low means applied or applying
// - drive response to enable delayed by release delay after brake opens
// - release delay 16 bit ms setting, range 0..1000
// - enable withdrawn: brake-release low at once, motor current kept for apply delay
// - apply delay 16 bit ms setting, range 0..1000
module ssb_sequencer
  import ssb_pkg::*;
#(
  parameter int MS_CYCLES = SSB_CYCLES_PER_MS
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               resetn,
  // parameter access
  input  wire logic [15:0]        regAddr,
  input  wire logic [15:0]        regWrData,
  input  wire logic               regWrite,
  output logic [15:0]             regRdData,
  // position controller
  input  wire logic signed [31:0] ctrlDeviation,
  input  wire logic               targetReached,
  input  wire logic               profileDone,
  output logic                    motionEnd,
  output logic                    settleTimeoutErr,
  // drive enable and power stage
  input  wire logic               enableCmd,
  input  wire logic               holdingTorque,
  output logic                    stageEnable,
  output logic                    motionEnable,
  // brake driver module
  output logic                    brakeReleaseOutput
);

  typedef struct packed {
    ssb_brake_state_type brk;
    logic                brakeOut;
    logic                stageOn;
    logic                motionOn;
    logic                active;
    logic                motionEnd;
    logic                timeoutErr;
    logic [15:0]         win;
    logic [15:0]         dwell;
    logic [15:0]         tout;
    logic [15:0]         openDelay;
    logic [15:0]         closeDelay;
    logic [15:0]         rdData;
  } ssb_seq_state_type;

  ssb_seq_state_type st_r;
  ssb_seq_state_type st_nxt;

  logic [31:0] devMag;
  logic        inWindow;
  logic        startPulse;
  logic [15:0] dwellMs;
  logic [15:0] toutMs;
  logic [15:0] brkMs;
  logic        dwellClr;
  logic        toutClr;
  logic        brkClr;

  function automatic logic [15:0] clampTo(input logic [15:0] v, input logic [15:0] lim);
    clampTo = (v > lim) ? lim : v;
  endfunction

  // magnitude as unsigned, so the most negative value still compares right
  assign devMag     = ctrlDeviation[31] ? (32'h00000000 - ctrlDeviation) : ctrlDeviation;
  assign inWindow   = (devMag <= {16'h0000, st_r.win});
  assign startPulse = targetReached | profileDone;

  // dwell restarts whenever the deviation leaves the window
  // a restart during a move must count both windows afresh
  assign dwellClr = startPulse || !(st_r.active && inWindow && (st_r.dwell != 16'h0000));
  assign toutClr  = startPulse || !st_r.active;
  assign brkClr   = (st_r.brk != st_nxt.brk) || (st_r.brk == SSB_BRK_OFF) || (st_r.brk == SSB_BRK_ON)
                    || ((st_r.brk == SSB_BRK_OPENING) && !st_r.brakeOut);

  ssb_ms_timer #(.MS_CYCLES(MS_CYCLES)) uDwell (
    .clk     (clk),
    .resetn  (resetn),
    .clear   (dwellClr),
    .msCount (dwellMs)
  );

  ssb_ms_timer #(.MS_CYCLES(MS_CYCLES)) uTimeout (
    .clk     (clk),
    .resetn  (resetn),
    .clear   (toutClr),
    .msCount (toutMs)
  );

  ssb_ms_timer #(.MS_CYCLES(MS_CYCLES)) uBrake (
    .clk     (clk),
    .resetn  (resetn),
    .clear   (brkClr),
    .msCount (brkMs)
  );

  always_comb begin
    st_nxt = st_r;

    // settings, clamped to their legal range on write
    if (regWrite) begin
      if (regAddr == SSB_OFS_SETTLE_WINDOW) begin
        st_nxt.win = clampTo(regWrData, SSB_MAX_WINDOW);
      end else if (regAddr == SSB_OFS_SETTLE_DWELL) begin
        st_nxt.dwell = clampTo(regWrData, SSB_MAX_DWELL);
      end else if (regAddr == SSB_OFS_SETTLE_TIMEOUT) begin
        st_nxt.tout = clampTo(regWrData, SSB_MAX_TIMEOUT);
      end else if (regAddr == SSB_OFS_BRAKE_OPEN_DELAY) begin
        st_nxt.openDelay = clampTo(regWrData, SSB_MAX_DELAY);
      end else if (regAddr == SSB_OFS_BRAKE_CLOSE_DELAY) begin
        st_nxt.closeDelay = clampTo(regWrData, SSB_MAX_DELAY);
      end
    end

    // read data, unmapped addresses read zero
    if (regAddr == SSB_OFS_SETTLE_WINDOW) begin
      st_nxt.rdData = st_r.win;
    end else if (regAddr == SSB_OFS_SETTLE_DWELL) begin
      st_nxt.rdData = st_r.dwell;
    end else if (regAddr == SSB_OFS_SETTLE_TIMEOUT) begin
      st_nxt.rdData = st_r.tout;
    end else if (regAddr == SSB_OFS_BRAKE_OPEN_DELAY) begin
      st_nxt.rdData = st_r.openDelay;
    end else if (regAddr == SSB_OFS_BRAKE_CLOSE_DELAY) begin
      st_nxt.rdData = st_r.closeDelay;
    end else if (regAddr == SSB_OFS_STATUS) begin
      st_nxt.rdData                 = 16'h0000;
      st_nxt.rdData[SSB_STAT_END]    = st_r.motionEnd;
      st_nxt.rdData[SSB_STAT_ERR]    = st_r.timeoutErr;
      st_nxt.rdData[SSB_STAT_BRAKE]  = st_r.brakeOut;
      st_nxt.rdData[SSB_STAT_STAGE]  = st_r.stageOn;
      st_nxt.rdData[SSB_STAT_MOTION] = st_r.motionOn;
      st_nxt.rdData[SSB_STAT_STATE +: 2] = st_r.brk;
    end else begin
      st_nxt.rdData = 16'h0000;
    end

    // standstill monitoring
    if (st_r.active) begin
      if (dwellMs >= st_r.dwell) begin
        st_nxt.motionEnd = 1'b1;
        st_nxt.active    = 1'b0;
      end else if ((st_r.tout != 16'h0000) && (toutMs >= st_r.tout)) begin
        st_nxt.timeoutErr = 1'b1;
        st_nxt.active     = 1'b0;
      end
    end
    // a new move end restarts both monitors, or reports end at once when dwell is zero
    if (startPulse) begin
      st_nxt.timeoutErr = 1'b0;
      if (st_r.dwell == 16'h0000) begin
        // monitoring off: report end without checking the window
        st_nxt.motionEnd = 1'b1;
        st_nxt.active    = 1'b0;
      end else begin
        st_nxt.motionEnd = 1'b0;
        st_nxt.active    = 1'b1;
      end
    end

    // brake sequence
    case (st_r.brk)
      SSB_BRK_OFF: begin
        st_nxt.brakeOut = 1'b0;
        st_nxt.stageOn  = 1'b0;
        st_nxt.motionOn = 1'b0;
        if (enableCmd) begin
          st_nxt.brk     = SSB_BRK_OPENING;
          st_nxt.stageOn = 1'b1;
        end
      end
      SSB_BRK_OPENING: begin
        if (!enableCmd) begin
          st_nxt.brk      = SSB_BRK_CLOSING;
          st_nxt.brakeOut = 1'b0;
        end else if (holdingTorque) begin
          st_nxt.brakeOut = 1'b1;
          if (st_r.brakeOut && (brkMs >= st_r.openDelay)) begin
            // motion only once the brake had its time to open
            st_nxt.brk      = SSB_BRK_ON;
            st_nxt.motionOn = 1'b1;
          end
        end
      end
      SSB_BRK_ON: begin
        if (!enableCmd) begin
          st_nxt.brk      = SSB_BRK_CLOSING;
          st_nxt.brakeOut = 1'b0;
          st_nxt.motionOn = 1'b0;
        end
      end
      SSB_BRK_CLOSING: begin
        st_nxt.brakeOut = 1'b0;
        st_nxt.motionOn = 1'b0;
        // current held while the brake closes, then removed
        if (brkMs >= st_r.closeDelay) begin
          st_nxt.brk     = SSB_BRK_OFF;
          st_nxt.stageOn = 1'b0;
        end
      end
      default: begin
        st_nxt.brk      = SSB_BRK_OFF;
        st_nxt.brakeOut = 1'b0;
        st_nxt.stageOn  = 1'b0;
        st_nxt.motionOn = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r            <= '0;
      st_r.brk        <= SSB_BRK_OFF;
      st_r.win        <= SSB_RST_WINDOW;
      st_r.dwell      <= SSB_RST_DWELL;
      st_r.tout       <= SSB_RST_TIMEOUT;
      st_r.openDelay  <= SSB_RST_OPEN;
      st_r.closeDelay <= SSB_RST_CLOSE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign regRdData          = st_r.rdData;
  assign motionEnd          = st_r.motionEnd;
  assign settleTimeoutErr   = st_r.timeoutErr;
  assign stageEnable        = st_r.stageOn;
  assign motionEnable       = st_r.motionOn;
  assign brakeReleaseOutput = st_r.brakeOut;

  // checks
  property p_brake_drop;
    @(posedge clk) disable iff (!resetn)
      (!enableCmd && (st_r.brk != SSB_BRK_OFF)) |=> !brakeReleaseOutput;
  endproperty
  a_brake_drop: assert property (p_brake_drop) else $error("brake output not dropped");

  property p_stage_held;
    @(posedge clk) disable iff (!resetn)
      $fell(brakeReleaseOutput) && (st_r.brk == SSB_BRK_CLOSING) |-> stageEnable;
  endproperty
  a_stage_held: assert property (p_stage_held) else $error("current removed with brake");

  property p_release_on;
    @(posedge clk) disable iff (!resetn)
      (st_r.brk == SSB_BRK_OPENING) && enableCmd && holdingTorque |=> brakeReleaseOutput;
  endproperty
  a_release_on: assert property (p_release_on) else $error("brake not released");

  property p_motion_after_open;
    @(posedge clk) disable iff (!resetn)
      $rose(motionEnable) |-> brakeReleaseOutput && ($past(brkMs) >= st_r.openDelay);
  endproperty
  a_motion_after_open: assert property (p_motion_after_open) else $error("motion before delay");

  property p_end_in_window;
    @(posedge clk) disable iff (!resetn)
      $rose(motionEnd) && !$past(startPulse) |->
        ($past(st_r.dwell) == 16'h0000) || ($past(inWindow) && ($past(dwellMs) >= st_r.dwell));
  endproperty
  a_end_in_window: assert property (p_end_in_window) else $error("end without dwell");

  property p_dwell_zero;
    @(posedge clk) disable iff (!resetn)
      startPulse && (st_r.dwell == 16'h0000) |=> motionEnd && !settleTimeoutErr;
  endproperty
  a_dwell_zero: assert property (p_dwell_zero) else $error("disabled monitor blocked end");

  property p_tout_off;
    @(posedge clk) disable iff (!resetn)
      (st_r.tout == 16'h0000) && !startPulse |=> !$rose(settleTimeoutErr);
  endproperty
  a_tout_off: assert property (p_tout_off) else $error("timeout while disabled");

  property p_err_cause;
    @(posedge clk) disable iff (!resetn)
      $rose(settleTimeoutErr) |-> ($past(toutMs) >= st_r.tout) && !motionEnd;
  endproperty
  a_err_cause: assert property (p_err_cause) else $error("early timeout");

  property p_start;
    @(posedge clk) disable iff (!resetn)
      startPulse && (st_r.dwell != 16'h0000) |=> !motionEnd && !settleTimeoutErr ##1 (toutMs == 16'h0000);
  endproperty
  a_start: assert property (p_start) else $error("monitor not restarted");

  property p_dwell_restart;
    @(posedge clk) disable iff (!resetn)
      !inWindow |=> (dwellMs == 16'h0000);
  endproperty
  a_dwell_restart: assert property (p_dwell_restart) else $error("dwell not restarted");

  property p_limits;
    @(posedge clk) disable iff (!resetn)
      (st_r.win <= SSB_MAX_WINDOW) && (st_r.openDelay <= SSB_MAX_DELAY) && (st_r.closeDelay <= SSB_MAX_DELAY);
  endproperty
  a_limits: assert property (p_limits) else $error("setting out of range");

  c_end: cover property (@(posedge clk) disable iff (!resetn) $rose(motionEnd));
  c_err: cover property (@(posedge clk) disable iff (!resetn) $rose(settleTimeoutErr));
  c_motion: cover property (@(posedge clk) disable iff (!resetn) $rose(motionEnable));
  c_close: cover property (@(posedge clk) disable iff (!resetn) $fell(stageEnable));

endmodule // ssb_sequencer

// ==== rtl/ssb_pkg.sv ====
// shared constants and types of the standstill and brake sequencer
package ssb_pkg;

  // register offsets (16-bit parameter addresses)
  localparam logic [15:0] SSB_OFS_BRAKE_OPEN_DELAY  = 16'h050E;
  localparam logic [15:0] SSB_OFS_BRAKE_CLOSE_DELAY = 16'h0510;
  localparam logic [15:0] SSB_OFS_SETTLE_WINDOW     = 16'h1112;
  localparam logic [15:0] SSB_OFS_SETTLE_DWELL      = 16'h1114;
  localparam logic [15:0] SSB_OFS_SETTLE_TIMEOUT    = 16'h1116;
  localparam logic [15:0] SSB_OFS_STATUS            = 16'h1118;

  // values after reset
  localparam logic [15:0] SSB_RST_WINDOW  = 16'h000A;
  localparam logic [15:0] SSB_RST_DWELL   = 16'h0000;
  localparam logic [15:0] SSB_RST_TIMEOUT = 16'h0000;
  localparam logic [15:0] SSB_RST_OPEN    = 16'h0000;
  localparam logic [15:0] SSB_RST_CLOSE   = 16'h0000;

  // upper limits of the settings
  localparam logic [15:0] SSB_MAX_WINDOW  = 16'h7FFF;
  localparam logic [15:0] SSB_MAX_DWELL   = 16'h7FFF;
  localparam logic [15:0] SSB_MAX_TIMEOUT = 16'h3E80;
  localparam logic [15:0] SSB_MAX_DELAY   = 16'h03E8;

  // status register field positions
  localparam int SSB_STAT_END    = 0;
  localparam int SSB_STAT_ERR    = 1;
  localparam int SSB_STAT_BRAKE  = 2;
  localparam int SSB_STAT_STAGE  = 3;
  localparam int SSB_STAT_MOTION = 4;
  localparam int SSB_STAT_STATE  = 5;

  // timing: one millisecond at the system clock
  localparam int SSB_CLK_PERIOD_NS = 40;
  localparam int SSB_MS_NS         = 1000000;
  localparam int SSB_CYCLES_PER_MS = SSB_MS_NS / SSB_CLK_PERIOD_NS;

  // brake sequence, gray coded along open -> on -> close -> off
  typedef enum logic [1:0] {
    SSB_BRK_OFF     = 2'b00,
    SSB_BRK_OPENING = 2'b01,
    SSB_BRK_ON      = 2'b11,
    SSB_BRK_CLOSING = 2'b10
  } ssb_brake_state_type;

endpackage : ssb_pkg

// ==== rtl/ssb_ms_timer.sv ====
// millisecond elapsed-time counter with synchronous restart
module ssb_ms_timer
  import ssb_pkg::*;
#(
  parameter int MS_CYCLES = SSB_CYCLES_PER_MS
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // control
  input  wire logic        clear,
  // elapsed milliseconds, saturating
  output logic [15:0]      msCount
);

  typedef struct packed {
    logic [23:0] pre;
    logic [15:0] ms;
  } ssb_timer_state_type;

  ssb_timer_state_type st_r;
  ssb_timer_state_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (clear) begin
      st_nxt.pre = 24'h000000;
      st_nxt.ms  = 16'h0000;
    end else if (st_r.pre == 24'(MS_CYCLES - 1)) begin
      st_nxt.pre = 24'h000000;
      // saturate rather than wrap, so a long wait never looks short
      if (st_r.ms != 16'hFFFF) begin
        st_nxt.ms = st_r.ms + 16'h0001;
      end
    end else begin
      st_nxt.pre = st_r.pre + 24'h000001;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign msCount = st_r.ms;

endmodule // ssb_ms_timer

// ==== test/ssb_brake_motor_model.sv ====
// brake driver module and servo motor model at the far side of the sequencer
module ssb_brake_motor_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // from the sequencer
  input  wire logic       stageEnable,
  input  wire logic       brakeReleaseOutput,
  // cycles from stage on until the motor holds torque (prompt or slow motor)
  input  wire logic [3:0] torqueDelay,
  // to the sequencer and the bench
  output logic            holdingTorque,
  output logic            brakeOpen
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] torqueCnt;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      // power-up leaves the brake terminals unpowered, brake applied
      brakeOpen     <= 1'b0;
      torqueCnt     <= 4'h0;
      holdingTorque <= 1'b0;
    end else begin
      // driver follows the release line one cycle late, as an amplifier would
      brakeOpen <= brakeReleaseOutput;
      // torque lost at once when current is removed
      if (!stageEnable) begin
        torqueCnt     <= 4'h0;
        holdingTorque <= 1'b0;
      end else if (torqueCnt >= torqueDelay) begin
        holdingTorque <= 1'b1;
      end else begin
        torqueCnt <= torqueCnt + 4'h1;
      end
    end
  end
endmodule // ssb_brake_motor_model

// ==== test/testbench.sv ====
// self-checking bench of the standstill and brake sequencer
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ssb_pkg::*;

  // short millisecond keeps the run brief
  localparam int MS = 4;

  logic               clk;
  logic               resetn;
  logic [15:0]        regAddr;
  logic [15:0]        regWrData;
  logic               regWrite;
  logic [15:0]        regRdData;
  logic signed [31:0] ctrlDeviation;
  logic               targetReached;
  logic               profileDone;
  logic               motionEnd;
  logic               settleTimeoutErr;
  logic               enableCmd;
  logic               holdingTorque;
  logic               stageEnable;
  logic               motionEnable;
  logic               brakeReleaseOutput;
  logic               brakeOpen;
  logic [3:0]         torqueDelay;
  logic [15:0]        rd;
  int                 errCount;
  int                 checks;
  int                 n;

  `define CHK(a, e) begin checks++; if ((a) !== (e)) begin errCount++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
  `define WAITFOR(c, lim) begin n = 0; while (!(c) && n < (lim)) begin tick(1); n++; end \
    if (!(c)) begin errCount++; $display("MISMATCH t=%0t wait bound %0h", $time, lim); final_report(); end end

  ssb_sequencer #(.MS_CYCLES(MS)) u_ssb_sequencer (
    .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRdData(regRdData), .ctrlDeviation(ctrlDeviation), .targetReached(targetReached),
    .profileDone(profileDone), .motionEnd(motionEnd), .settleTimeoutErr(settleTimeoutErr),
    .enableCmd(enableCmd), .holdingTorque(holdingTorque), .stageEnable(stageEnable),
    .motionEnable(motionEnable), .brakeReleaseOutput(brakeReleaseOutput));

  ssb_brake_motor_model u_ssb_brake_motor_model (
    .clk(clk), .resetn(resetn), .stageEnable(stageEnable), .brakeReleaseOutput(brakeReleaseOutput),
    .torqueDelay(torqueDelay), .holdingTorque(holdingTorque), .brakeOpen(brakeOpen));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic final_report();
    $display("checks=%0d errors=%0d", checks, errCount);
    if (errCount == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // all input changes land 1 ns after the rising edge
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic wrReg(input logic [15:0] a, input logic [15:0] d);
    regAddr   = a;
    regWrData = d;
    regWrite  = 1'b1;
    tick(1);
    regWrite  = 1'b0;
    // one idle edge so back-to-back writes never retoggle the strobe at once
    tick(1);
  endtask

  // address sampled and data registered at the same edge, one spare edge follows
  task automatic rdReg(input logic [15:0] a, output logic [15:0] d);
    regAddr = a;
    tick(2);
    d = regRdData;
  endtask

  task automatic startMove(input logic viaProfile);
    targetReached = !viaProfile;
    profileDone   = viaProfile;
    tick(1);
    targetReached = 1'b0;
    profileDone   = 1'b0;
  endtask

  task automatic brakeRun(input logic [3:0] td, input int openMs, input int closeMs);
    torqueDelay = td;
    wrReg(SSB_OFS_BRAKE_OPEN_DELAY, 16'(openMs));
    wrReg(SSB_OFS_BRAKE_CLOSE_DELAY, 16'(closeMs));
    enableCmd = 1'b1;
    tick(1);
    `CHK(stageEnable, 1'b1)
    `CHK(brakeReleaseOutput, 1'b0)
    `WAITFOR(brakeReleaseOutput, 32'(td) + 6)
    `CHK(holdingTorque, 1'b1)
    `CHK(motionEnable, 1'b0)
    if (openMs > 0) begin
      tick(openMs * MS - 1);
      `CHK(motionEnable, 1'b0)
    end
    `WAITFOR(motionEnable, 8)
    rdReg(SSB_OFS_STATUS, rd);
    `CHK(rd[6:2], 5'h1F)
    `CHK(brakeOpen, 1'b1)
    enableCmd = 1'b0;
    tick(1);
    `CHK(brakeReleaseOutput, 1'b0)
    `CHK(motionEnable, 1'b0)
    `CHK(stageEnable, 1'b1)
    if (closeMs > 0) begin
      tick(closeMs * MS - 2);
      `CHK(stageEnable, 1'b1)
    end
    `WAITFOR(!stageEnable, 8)
  endtask

  // rows: write flag, address, data, expected read back
  localparam int NROWS = 14;
  localparam logic [48:0] ROWS [NROWS] = '{
    {1'b0, SSB_OFS_SETTLE_WINDOW, 16'h0000, 16'h000A},
    {1'b0, SSB_OFS_SETTLE_DWELL, 16'h0000, 16'h0000},
    {1'b0, SSB_OFS_SETTLE_TIMEOUT, 16'h0000, 16'h0000},
    {1'b1, SSB_OFS_SETTLE_WINDOW, 16'hFFFF, 16'h7FFF},
    {1'b1, SSB_OFS_SETTLE_DWELL, 16'h8000, 16'h7FFF},
    {1'b1, SSB_OFS_SETTLE_TIMEOUT, 16'hFFFF, 16'h3E80},
    {1'b1, SSB_OFS_SETTLE_TIMEOUT, 16'h3E80, 16'h3E80},
    {1'b1, SSB_OFS_BRAKE_OPEN_DELAY, 16'h03E9, 16'h03E8},
    {1'b1, SSB_OFS_BRAKE_CLOSE_DELAY, 16'hFFFF, 16'h03E8},
    {1'b1, SSB_OFS_BRAKE_CLOSE_DELAY, 16'h03E7, 16'h03E7},
    {1'b1, SSB_OFS_SETTLE_WINDOW, 16'h0000, 16'h0000},
    {1'b1, SSB_OFS_SETTLE_WINDOW, 16'h000A, 16'h000A},
    {1'b1, 16'h2000, 16'h1234, 16'h0000},
    {1'b1, SSB_OFS_STATUS, 16'hFFFF, 16'h0000}
  };

  initial begin
    resetn = 1'b0;
    regAddr = 16'h0000;
    regWrData = 16'h0000;
    regWrite = 1'b0;
    ctrlDeviation = 32'sh0;
    targetReached = 1'b0;
    profileDone = 1'b0;
    enableCmd = 1'b0;
    torqueDelay = 4'h1;
    errCount = 0;
    checks = 0;
    tick(2);
    `CHK({motionEnd, settleTimeoutErr, stageEnable, motionEnable, brakeReleaseOutput}, 5'h00)
    `CHK(brakeOpen, 1'b0)
    resetn = 1'b1;
    tick(1);
    for (int i = 0; i < NROWS; i++) begin
      if (ROWS[i][48]) wrReg(ROWS[i][47:32], ROWS[i][31:16]);
      rdReg(ROWS[i][47:32], rd);
      `CHK(rd, ROWS[i][15:0])
    end
    // dwell of 2 ms, deviation negative but inside the window edge
    wrReg(SSB_OFS_SETTLE_TIMEOUT, 16'h0000);
    wrReg(SSB_OFS_SETTLE_DWELL, 16'h0002);
    ctrlDeviation = -32'sd10;
    startMove(1'b0);
    tick(2 * MS - 2);
    `CHK(motionEnd, 1'b0)
    `WAITFOR(motionEnd, 8)
    // a one-cycle excursion restarts the dwell
    startMove(1'b1);
    tick(4);
    ctrlDeviation = 32'sd11;
    tick(1);
    ctrlDeviation = -32'sd3;
    tick(2 * MS - 2);
    `CHK(motionEnd, 1'b0)
    `WAITFOR(motionEnd, 8)
    // never settles: timeout of 3 ms raises the error
    wrReg(SSB_OFS_SETTLE_TIMEOUT, 16'h0003);
    ctrlDeviation = 32'sd100;
    startMove(1'b1);
    tick(3 * MS - 2);
    `CHK(settleTimeoutErr, 1'b0)
    `WAITFOR(settleTimeoutErr, 8)
    `CHK(motionEnd, 1'b0)
    startMove(1'b0);
    `CHK(settleTimeoutErr, 1'b0)
    // timeout off: no error however long it waits
    wrReg(SSB_OFS_SETTLE_TIMEOUT, 16'h0000);
    startMove(1'b0);
    tick(40);
    `CHK(settleTimeoutErr, 1'b0)
    `CHK(motionEnd, 1'b0)
    // dwell off: no window check at all
    wrReg(SSB_OFS_SETTLE_DWELL, 16'h0000);
    startMove(1'b1);
    `CHK(motionEnd, 1'b1)
    // brake sequence with prompt and slow motor
    brakeRun(4'h1, 2, 3);
    brakeRun(4'h6, 0, 0);
    // reset in mid-run with the brake open: all off, window setting reads its default
    enableCmd = 1'b1;
    `WAITFOR(motionEnable, 16)
    resetn    = 1'b0;
    enableCmd = 1'b0;
    tick(2);
    `CHK({motionEnd, stageEnable, motionEnable, brakeReleaseOutput}, 4'h0)
    `CHK(brakeOpen, 1'b0)
    resetn = 1'b1;
    tick(1);
    rdReg(SSB_OFS_SETTLE_WINDOW, rd);
    `CHK(rd, 16'h000A)
    final_report();
  end
endmodule // testbench
